// ### core/gpp_ports.sv
/*
 gpp_ports: two five-bit general purpose ports behind a classic wishbone slave.
 assumes one clock, synchronous reset, pins resolved outside from out and enable (low drives).
*/
`timescale 1ns/100ps
`default_nettype none
module gpp_ports (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [13:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [4:0] port_a_pin_i,
  output logic [4:0] port_a_pin_o,
  output logic [4:0] port_a_pin_oe_n_o,
  input wire logic [4:0] port_b_pin_i,
  output logic [4:0] port_b_pin_o,
  output logic [4:0] port_b_pin_oe_n_o,
  output logic [4:0] port_b_pullup_en_o,
  input wire logic pulse_gen_output_a_i,
  input wire logic pulse_gen_output_b_i,
  output logic timer_ext_input_a_o,
  output logic timer_ext_input_b_o,
  input wire logic uart_one_transmit_i,
  input wire logic uart_two_transmit_i,
  input wire logic serial_one_clock_out_i,
  output logic uart_one_receive_o,
  output logic uart_two_receive_o,
  output logic serial_one_clock_in_o
);
  logic [4:0] a_latch, a_dir, a_func, b_latch, b_dir, b_func, b_type, b_pullup;
  logic [4:0] next_a_latch, next_a_dir, next_a_func;
  logic [4:0] next_b_latch, next_b_dir, next_b_func, next_b_type, next_b_pullup;
  logic [31:0] next_dat;
  logic next_ack;
  logic [4:0] a_sync, b_sync;
  logic [4:0] a_drv, b_drv, next_a_out, next_a_oe_n, next_b_out, next_b_oe_n, next_b_pu;
  logic next_tia, next_tib, next_u1, next_u2, next_sck;
  logic [11:0] idx;
  logic wr, rd_ok, req;
  logic [4:0] wdata;

  gpp_sync #(.W(5)) u_sync_a (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i(port_a_pin_i),
    .sync_o(a_sync)
  );
  gpp_sync #(.W(5)) u_sync_b (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i(port_b_pin_i),
    .sync_o(b_sync)
  );

  assign idx = wb_adr_i[13:2];
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0]
    && (wb_adr_i[1:0] == 2'h0);
  assign wdata = wb_dat_i[4:0];

  // register writes
  always_comb begin
    next_a_latch = a_latch;
    next_a_dir = a_dir;
    next_a_func = a_func;
    next_b_latch = b_latch;
    next_b_dir = b_dir;
    next_b_func = b_func;
    next_b_type = b_type;
    next_b_pullup = b_pullup;
    if (wr) begin
      case (idx)
        gpp_pkg::IDX_A_LATCH: next_a_latch = wdata;
        gpp_pkg::IDX_A_DIR: next_a_dir = wdata;
        gpp_pkg::IDX_A_FUNC: next_a_func = wdata & gpp_pkg::A_FUNC_MASK;
        gpp_pkg::IDX_B_LATCH: next_b_latch = wdata;
        gpp_pkg::IDX_B_DIR: next_b_dir = wdata;
        gpp_pkg::IDX_B_FUNC: next_b_func = wdata & gpp_pkg::B_FUNC_MASK;
        gpp_pkg::IDX_B_TYPE: next_b_type = wdata;
        gpp_pkg::IDX_B_PULLUP: next_b_pullup = wdata;
        default: next_a_latch = a_latch;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      a_latch <= gpp_pkg::RESET_VAL;
      a_dir <= gpp_pkg::RESET_VAL;
      a_func <= gpp_pkg::RESET_VAL;
      b_latch <= gpp_pkg::RESET_VAL;
      b_dir <= gpp_pkg::RESET_VAL;
      b_func <= gpp_pkg::RESET_VAL;
      b_type <= gpp_pkg::RESET_VAL;
      b_pullup <= gpp_pkg::RESET_VAL;
    end else begin
      a_latch <= next_a_latch;
      a_dir <= next_a_dir;
      a_func <= next_a_func;
      b_latch <= next_b_latch;
      b_dir <= next_b_dir;
      b_func <= next_b_func;
      b_type <= next_b_type;
      b_pullup <= next_b_pullup;
    end
  end

  // bus answer, one cycle after the request
  always_comb begin
    next_ack = req;
    rd_ok = 1'b1;
    next_dat = 32'h00000000;
    case (idx)
      gpp_pkg::IDX_A_LATCH: next_dat[4:0] = a_latch;
      gpp_pkg::IDX_A_DIR: next_dat[4:0] = a_dir;
      gpp_pkg::IDX_A_FUNC: next_dat[4:0] = a_func;
      gpp_pkg::IDX_A_READ: next_dat[4:0] = a_sync & ~a_dir;
      gpp_pkg::IDX_B_LATCH: next_dat[4:0] = b_latch;
      gpp_pkg::IDX_B_DIR: next_dat[4:0] = b_dir;
      gpp_pkg::IDX_B_FUNC: next_dat[4:0] = b_func;
      gpp_pkg::IDX_B_TYPE: next_dat[4:0] = b_type;
      gpp_pkg::IDX_B_PULLUP: next_dat[4:0] = b_pullup;
      gpp_pkg::IDX_B_READ: next_dat[4:0] = b_sync & (~b_dir | b_type);
      default: rd_ok = 1'b0;
    endcase
    if (!req || wb_we_i || !rd_ok) begin
      next_dat = 32'h00000000;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= next_ack;
      wb_dat_o <= next_dat;
    end
  end

  // pin drive and peripheral routing
  always_comb begin
    a_drv = a_latch;
    a_drv[0] = a_func[0] ? pulse_gen_output_a_i : a_latch[0];
    a_drv[1] = a_func[1] ? pulse_gen_output_b_i : a_latch[1];
    next_a_out = a_drv;
    next_a_oe_n = ~a_dir;
    b_drv = b_latch;
    b_drv[0] = b_func[0] ? uart_one_transmit_i : b_latch[0];
    b_drv[2] = b_func[2] ? serial_one_clock_out_i : b_latch[2];
    b_drv[3] = b_func[3] ? uart_two_transmit_i : b_latch[3];
    next_b_out = b_drv & ~b_type;
    next_b_oe_n = ~(b_dir & (~b_type | ~b_drv));
    next_b_pu = b_pullup & (~b_dir | b_type);
    next_tia = a_sync[0] & ~a_dir[0];
    next_tib = a_sync[1] & ~a_dir[1];
    next_u1 = b_sync[1] & ~b_dir[1];
    next_u2 = b_sync[4] & ~b_dir[4];
    next_sck = b_sync[2] & ~b_dir[2];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_a_pin_o <= 5'h00;
      port_a_pin_oe_n_o <= 5'h1F;
      port_b_pin_o <= 5'h00;
      port_b_pin_oe_n_o <= 5'h1F;
      port_b_pullup_en_o <= 5'h00;
      timer_ext_input_a_o <= 1'b0;
      timer_ext_input_b_o <= 1'b0;
      uart_one_receive_o <= 1'b0;
      uart_two_receive_o <= 1'b0;
      serial_one_clock_in_o <= 1'b0;
    end else begin
      port_a_pin_o <= next_a_out;
      port_a_pin_oe_n_o <= next_a_oe_n;
      port_b_pin_o <= next_b_out;
      port_b_pin_oe_n_o <= next_b_oe_n;
      port_b_pullup_en_o <= next_b_pu;
      timer_ext_input_a_o <= next_tia;
      timer_ext_input_b_o <= next_tib;
      uart_one_receive_o <= next_u1;
      uart_two_receive_o <= next_u2;
      serial_one_clock_in_o <= next_sck;
    end
  end

  property p_ack_one;
    @(posedge clk_i) disable iff (rst_i)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("no ack after request");

  property p_a_read;
    @(posedge clk_i) disable iff (rst_i)
    (req && !wb_we_i && idx == gpp_pkg::IDX_A_READ) |=>
      (wb_dat_o[4:0] == ($past(a_sync) & ~$past(a_dir)) && wb_dat_o[31:5] == 27'h0);
  endproperty
  a_a_read: assert property (p_a_read) else $error("port a readback wrong");

  property p_b_read;
    @(posedge clk_i) disable iff (rst_i)
    (req && !wb_we_i && idx == gpp_pkg::IDX_B_READ) |=>
      wb_dat_o[4:0] == ($past(b_sync) & (~$past(b_dir) | $past(b_type)));
  endproperty
  a_b_read: assert property (p_b_read) else $error("port b readback wrong");

  property p_a_drive;
    @(posedge clk_i) disable iff (rst_i)
    (a_dir[4] && !$past(rst_i)) |=> (port_a_pin_oe_n_o[4] == 1'b0 && port_a_pin_o[4] == $past(a_latch[4]));
  endproperty
  a_a_drive: assert property (p_a_drive) else $error("port a drive wrong");

  property p_a_input;
    @(posedge clk_i) disable iff (rst_i)
    (!a_dir[0]) |=> port_a_pin_oe_n_o[0];
  endproperty
  a_a_input: assert property (p_a_input) else $error("port a input driven");

  property p_a_func;
    @(posedge clk_i) disable iff (rst_i)
    (a_func[1]) |=> port_a_pin_o[1] == $past(pulse_gen_output_b_i);
  endproperty
  a_a_func: assert property (p_a_func) else $error("pulse output not routed");

  property p_od_high;
    @(posedge clk_i) disable iff (rst_i)
    (b_dir[1] && b_type[1] && b_latch[1]) |=> port_b_pin_oe_n_o[1];
  endproperty
  a_od_high: assert property (p_od_high) else $error("open drain drove high");

  property p_cmos_high;
    @(posedge clk_i) disable iff (rst_i)
    (b_dir[1] && !b_type[1] && b_latch[1]) |=> (!port_b_pin_oe_n_o[1] && port_b_pin_o[1]);
  endproperty
  a_cmos_high: assert property (p_cmos_high) else $error("push pull not high");

  property p_pullup;
    @(posedge clk_i) disable iff (rst_i)
    (b_dir[3] && !b_type[3]) |=> !port_b_pullup_en_o[3];
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up in push pull");

  property p_reset;
    @(posedge clk_i) rst_i |=> (port_a_pin_oe_n_o == 5'h1F && port_b_pin_oe_n_o == 5'h1F);
  endproperty
  a_reset: assert property (p_reset) else $error("pins not inputs after reset");

  property p_uart_rx;
    @(posedge clk_i) disable iff (rst_i)
    (!b_dir[4]) |=> uart_two_receive_o == $past(b_sync[4]);
  endproperty
  a_uart_rx: assert property (p_uart_rx) else $error("uart receive not passed");

  property p_ack_drop;
    @(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("ack held past one cycle");

  property p_type_write;
    @(posedge clk_i) disable iff (rst_i)
    (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i[1:0] == 2'h0
      && idx == gpp_pkg::IDX_B_TYPE) |=> b_type == $past(wb_dat_i[4:0]);
  endproperty
  a_type_write: assert property (p_type_write) else $error("output type write lost");

  property p_afunc_write;
    @(posedge clk_i) disable iff (rst_i)
    (wr && idx == gpp_pkg::IDX_A_FUNC) |=> a_func == ($past(wdata) & gpp_pkg::A_FUNC_MASK);
  endproperty
  a_afunc_write: assert property (p_afunc_write) else $error("function mask lost");

  property p_b_route;
    @(posedge clk_i) disable iff (rst_i)
    b_func[3] |=> port_b_pin_o[3] == ($past(uart_two_transmit_i) & !$past(b_type[3]));
  endproperty
  a_b_route: assert property (p_b_route) else $error("uart transmit not routed");

  property p_timer_in;
    @(posedge clk_i) disable iff (rst_i)
    (!a_dir[0]) |=> timer_ext_input_a_o == $past(a_sync[0]);
  endproperty
  a_timer_in: assert property (p_timer_in) else $error("timer input not passed");

  property p_rx_blocked;
    @(posedge clk_i) disable iff (rst_i)
    b_dir[1] |=> !uart_one_receive_o;
  endproperty
  a_rx_blocked: assert property (p_rx_blocked) else $error("receive fed in output mode");

  property p_pullup_on;
    @(posedge clk_i) disable iff (rst_i)
    (b_pullup[0] && !b_dir[0]) |=> port_b_pullup_en_o[0];
  endproperty
  a_pullup_on: assert property (p_pullup_on) else $error("pull-up not connected");

  property p_reg_reset;
    @(posedge clk_i) rst_i |=>
      (a_latch == gpp_pkg::RESET_VAL && b_type == gpp_pkg::RESET_VAL);
  endproperty
  a_reg_reset: assert property (p_reg_reset) else $error("registers not cleared");
endmodule
`default_nettype wire

// ### core/gpp_pkg.sv
/*
 gpp_pkg: register map, field layout and reset values of the two five-bit ports.
 assumes a classic wishbone slave with 32-bit data; byte addresses are four times each index.
*/
package gpp_pkg;
  localparam int unsigned WIDTH = 5;
  localparam logic [11:0] IDX_A_LATCH = 12'h008;
  localparam logic [11:0] IDX_B_LATCH = 12'h009;
  localparam logic [11:0] IDX_A_READ = 12'h015;
  localparam logic [11:0] IDX_B_READ = 12'h016;
  localparam logic [11:0] IDX_A_DIR = 12'hF22;
  localparam logic [11:0] IDX_B_DIR = 12'hF23;
  localparam logic [11:0] IDX_B_PULLUP = 12'hF30;
  localparam logic [11:0] IDX_A_FUNC = 12'hF3C;
  localparam logic [11:0] IDX_B_FUNC = 12'hF3D;
  localparam logic [11:0] IDX_B_TYPE = 12'hF4A;
  localparam logic [4:0] A_FUNC_MASK = 5'h03;
  localparam logic [4:0] B_FUNC_MASK = 5'h0D;
  localparam logic [4:0] RESET_VAL = 5'h00;
  localparam int unsigned SYNC_STAGES = 2;
endpackage

// ### core/gpp_sync.sv
/*
 gpp_sync: two flip-flop synchroniser for a bus of pin levels.
 assumes inputs arrive asynchronously to clk_i.
*/
`timescale 1ns/100ps
`default_nettype none
module gpp_sync #(
  parameter int unsigned W = 5
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] next_stage1;
  logic [W-1:0] next_stage2;
  if (W < 1) begin : g_width_check
    $error("synchroniser width must be at least one");
  end
  always_comb begin
    next_stage1 = async_i;
    next_stage2 = stage1;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stage1 <= '0;
      stage2 <= '0;
    end else begin
      stage1 <= next_stage1;
      stage2 <= next_stage2;
    end
  end
  assign sync_o = stage2;
endmodule
`default_nettype wire

// ### verification/gpp_pins.sv
/*
 gpp_pins: pad and far-side model for one five-bit port.
 assumes enable low means the block drives; a bare released pad toggles each cycle.
*/
`timescale 1ns/100ps
`default_nettype none
module gpp_pins (
  input wire logic clk_i,
  input wire logic [4:0] out_i,
  input wire logic [4:0] oe_n_i,
  input wire logic [4:0] pull_i,
  input wire logic [4:0] ext_val_i,
  input wire logic [4:0] ext_en_i,
  output logic [4:0] pad_o
);
  logic [4:0] wob = 5'h0A;
  always_ff @(posedge clk_i) begin
    wob <= ~wob;
  end
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      if (!oe_n_i[i]) begin
        pad_o[i] = out_i[i];
      end else if (ext_en_i[i]) begin
        pad_o[i] = ext_val_i[i];
      end else if (pull_i[i]) begin
        pad_o[i] = 1'b1;
      end else begin
        pad_o[i] = wob[i];
      end
    end
  end
endmodule
`default_nettype wire

// ### verification/gpp_ports_bench.sv
/*
 gpp_ports_bench: random register setups compared against a shadow model.
 assumes gpp_pkg and the gpp_pins pad model; 20 MHz clock.
*/
`timescale 1ns/100ps
`default_nettype none
module gpp_ports_bench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [13:0] wb_adr_i = 14'h0000;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h00000000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [4:0] pa, pb, ao, aoe, bo, boe, bpu, fin;
  logic [4:0] prf = 5'h00;
  logic [4:0] eav = 5'h00;
  logic [4:0] eae = 5'h1F;
  logic [4:0] ebv = 5'h00;
  logic [4:0] ebe = 5'h1F;
  logic [11:0] ix[8] = '{gpp_pkg::IDX_A_LATCH, gpp_pkg::IDX_B_LATCH, gpp_pkg::IDX_A_DIR,
    gpp_pkg::IDX_B_DIR, gpp_pkg::IDX_B_PULLUP, gpp_pkg::IDX_A_FUNC, gpp_pkg::IDX_B_FUNC,
    gpp_pkg::IDX_B_TYPE};
  logic [4:0] mk[8] = '{5'h1F, 5'h1F, 5'h1F, 5'h1F, 5'h1F, gpp_pkg::A_FUNC_MASK,
    gpp_pkg::B_FUNC_MASK, 5'h1F};
  logic [4:0] sh[8] = '{default: 5'h00};
  int seed = 59;
  int err_count = 0;
  int total_checks = 0;
  gpp_ports gpp_ports_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .port_a_pin_i(pa),
    .port_a_pin_o(ao), .port_a_pin_oe_n_o(aoe), .port_b_pin_i(pb), .port_b_pin_o(bo),
    .port_b_pin_oe_n_o(boe), .port_b_pullup_en_o(bpu), .pulse_gen_output_a_i(prf[0]),
    .pulse_gen_output_b_i(prf[1]), .timer_ext_input_a_o(fin[0]),
    .timer_ext_input_b_o(fin[1]), .uart_one_transmit_i(prf[2]),
    .uart_two_transmit_i(prf[3]), .serial_one_clock_out_i(prf[4]),
    .uart_one_receive_o(fin[2]), .uart_two_receive_o(fin[3]),
    .serial_one_clock_in_o(fin[4]));
  gpp_pins pad_a (.clk_i(clk_i), .out_i(ao), .oe_n_i(aoe), .pull_i(5'h00),
    .ext_val_i(eav), .ext_en_i(eae), .pad_o(pa));
  gpp_pins pad_b (.clk_i(clk_i), .out_i(bo), .oe_n_i(boe), .pull_i(bpu),
    .ext_val_i(ebv), .ext_en_i(ebe), .pad_o(pb));
  initial begin
    forever #25 clk_i = ~clk_i;
  end
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk_rd(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("Error at %0t: read %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_pin(input logic [4:0] g, input logic [4:0] e);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("Error at %0t: port %h expected %h", $time, g, e);
    end
  endtask
  task automatic wb(input logic [11:0] idx, input logic we, input logic [3:0] sel,
      input logic [4:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_sel_i <= sel;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= {27'h0000000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 20) begin
      err_count++;
      $display("Error at %0t: no bus answer", $time);
      close_out();
    end
  endtask
  task automatic verify();
    logic [31:0] q;
    logic [4:0] va, vb, db, pe, fa, fb;
    for (int i = 0; i < 8; i++) begin
      wb(ix[i], 1'b0, 4'hF, 5'h00, q);
      chk_rd(q, {27'h0000000, sh[i]});
    end
    va = (sh[5] & {3'b000, prf[1:0]}) | (~sh[5] & sh[0]);
    vb = (sh[6] & {1'b0, prf[3], prf[4], 1'b0, prf[2]}) | (~sh[6] & sh[1]);
    db = sh[3] & ~(sh[7] & vb);
    pe = sh[4] & (~sh[3] | sh[7]);
    fa = ~sh[2] & ~eae;
    fb = ~db & ~ebe & ~pe;
    chk_pin(aoe, ~sh[2]);
    chk_pin(ao & sh[2], va & sh[2]);
    chk_pin(boe, ~db);
    chk_pin(bo & db, vb & db);
    chk_pin(bpu, pe);
    chk_pin(fin & ~{fb[2], fb[4], fb[1], fa[1:0]}, {pb[2], pb[4], pb[1], pa[1:0]} &
      ~{sh[3][2], sh[3][4], sh[3][1], sh[2][1:0]} & ~{fb[2], fb[4], fb[1], fa[1:0]});
    wb(gpp_pkg::IDX_A_READ, 1'b0, 4'hF, 5'h00, q);
    chk_rd(q & ~{27'h0, fa}, {27'h0, pa & ~sh[2] & ~fa});
    wb(gpp_pkg::IDX_B_READ, 1'b0, 4'hF, 5'h00, q);
    chk_rd(q & ~{27'h0, fb}, {27'h0, pb & (~sh[3] | sh[7]) & ~fb});
    wb(12'h123, 1'b0, 4'hF, 5'h00, q);
    chk_rd(q, 32'h00000000);
  endtask
  initial begin
    logic [31:0] q;
    logic [4:0] d;
    logic [3:0] s;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    verify();
    for (int k = 0; k < 40; k++) begin
      for (int i = 0; i < 8; i++) begin
        d = 5'($random(seed));
        s = 4'($random(seed));
        wb(ix[i], 1'b1, s, d, q);
        if (s[0]) begin
          sh[i] = d & mk[i];
        end
      end
      wb(gpp_pkg::IDX_A_READ, 1'b1, 4'hF, 5'h1F, q);
      prf <= 5'($random(seed));
      eav <= 5'($random(seed));
      eae <= 5'($random(seed));
      ebv <= 5'($random(seed));
      ebe <= 5'($random(seed));
      repeat (4) @(posedge clk_i);
      verify();
      if (k == 20) begin
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        sh = '{default: 5'h00};
        verify();
      end
    end
    close_out();
  end
endmodule
`default_nettype wire
